// *** hpc_regs.sv ***
// Register bank with AXI4-Lite slave, DMA data FIFOs and pin control
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic room_q;
  logic empty_q;
  logic push;
  logic pop;

  // Handshakes; ready is a flop itself so the top can pass it straight out
  assign push = ce && in_valid && room_q;
  assign pop = ce && out_ready && !empty_q;
  assign in_ready = room_q;
  assign out_valid = !empty_q;
  assign out_data = mem_q[rd_ptr_q];

  // Next fill level
  always_comb
  begin
    count_d = count_q + CW'(push) - CW'(pop);
  end

  // Level and flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_q <= '0;
      room_q <= 1'b1;
      empty_q <= 1'b1;
    end
    else
    begin
      count_q <= count_d;
      room_q <= (count_d != CW'(DEPTH));
      empty_q <= (count_d == '0);
    end
  end

  // Pointers wrap at DEPTH so any depth works
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
    end
  end

  // Storage needs no reset; empty flag masks stale words
  always_ff @(posedge aclk)
  begin
    if (push)
      mem_q[wr_ptr_q] <= in_data;
  end
endmodule : byte_fifo

module hpc_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic sleep_mode,
  input wire logic cpu_cut_mode,
  input wire logic byte_swap_strap,
  input wire logic write_strobe_strap,
  input wire logic irq_event,
  input wire logic dma_ack_pin,
  input wire logic chip_select_pin_n,
  input wire logic area_in_valid,
  output logic area_in_ready,
  input wire logic [7:0] area_in_data,
  output logic area_out_valid,
  input wire logic area_out_ready,
  output logic [7:0] area_out_data,
  output logic clock_origin_select,
  output logic [1:0] input_frequency_code,
  output logic ext_clk_enable,
  output logic irq_out_pin_o,
  output logic irq_out_pin_oe_n,
  output logic dma_request_pin,
  output logic dma_access
);
  logic awready_q, aw_have_q, aw_bad_q;
  logic [7:0] aw_idx_q;
  logic wready_q, w_have_q, wstrb0_q;
  logic [7:0] wdata_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  hpc_pkg::bus_state_t wst_q;
  logic arready_q, rvalid_q;
  logic [7:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] key_q;
  hpc_pkg::clk_setup_t clk_q;
  logic [4:0] hpc_rw_q;
  logic [1:0] strap_q;
  logic init_done_q, strap_taken_q;
  hpc_pkg::host_cfg_t hpc;
  hpc_pkg::dma_ctrl_t ctrl_q;
  logic area_out_valid_q;
  logic [7:0] area_out_data_q;
  logic ext_clk_q, irq_o_q, irq_oe_n_q, dreq_q, dacc_q;
  logic tx_in_ready, tx_out_valid, tx_out_ready;
  logic [7:0] tx_out_data;
  logic rx_out_valid, rx_in_ready;
  logic [7:0] rx_out_data;
  logic cfg_open, wr_ok, wr_is_push, push_armed, wr_stall, do_write, tx_push;
  logic ar_take, rd_ok, rd_is_pop, pop_armed, rx_pop;
  logic [7:0] ar_idx, rd_mux;
  logic req_active, ack_active;

  // Index known to the bank
  function automatic logic mapped(input logic [7:0] idx);
    mapped = (idx >= hpc_pkg::IDX_RD_LO && idx <= hpc_pkg::IDX_WR_HI)
      || idx == hpc_pkg::IDX_KEY || idx == hpc_pkg::IDX_CLK
      || idx == hpc_pkg::IDX_HPC || idx == hpc_pkg::IDX_CTRL
      || idx == hpc_pkg::IDX_STAT;
  endfunction : mapped

  // Only the data path sleeps; key, clock and configuration stay open
  function automatic logic sleep_gated(input logic [7:0] idx);
    sleep_gated = (idx >= hpc_pkg::IDX_RD_LO && idx <= hpc_pkg::IDX_WR_HI)
      || idx == hpc_pkg::IDX_CTRL;
  endfunction : sleep_gated

  assign hpc = {hpc_rw_q, strap_q, init_done_q};
  assign cfg_open = (key_q == hpc_pkg::UNLOCK_CODE);

  // Write decode; a push into a full FIFO holds the response back
  assign wr_ok = mapped(aw_idx_q) && !aw_bad_q
    && !(sleep_mode && sleep_gated(aw_idx_q));
  assign wr_is_push = aw_idx_q == hpc_pkg::IDX_WR_LO
    || aw_idx_q == hpc_pkg::IDX_WR_HI;
  assign push_armed = wr_ok && ctrl_q.dma_mode && !ctrl_q.dir_read
    && wstrb0_q;
  assign wr_stall = wr_is_push && push_armed && !tx_in_ready;
  assign do_write = ce && wst_q == hpc_pkg::BUS_WAIT && aw_have_q
    && w_have_q && !wr_stall;
  assign tx_push = do_write && wr_is_push && push_armed;

  // Read decode; an empty FIFO reads as zero and pops nothing
  assign ar_take = ce && arvalid && arready_q;
  assign ar_idx = araddr[9:hpc_pkg::ADDR_LSB];
  assign rd_ok = mapped(ar_idx) && araddr[11:10] == 2'h0
    && !(sleep_mode && sleep_gated(ar_idx));
  assign rd_is_pop = ar_idx == hpc_pkg::IDX_RD_LO
    || ar_idx == hpc_pkg::IDX_RD_HI;
  assign pop_armed = rd_ok && ctrl_q.dma_mode && ctrl_q.dir_read;
  assign rx_pop = ar_take && rd_is_pop && pop_armed && rx_out_valid;

  // Read data selection
  always_comb
  begin
    rd_mux = 8'h00;
    case (ar_idx)
      hpc_pkg::IDX_RD_LO, hpc_pkg::IDX_RD_HI:
        rd_mux = rx_pop ? rx_out_data : 8'h00;
      hpc_pkg::IDX_KEY: rd_mux = key_q;
      hpc_pkg::IDX_CLK: rd_mux = clk_q;
      hpc_pkg::IDX_HPC: rd_mux = hpc;
      hpc_pkg::IDX_CTRL: rd_mux = {6'h00, ctrl_q};
      hpc_pkg::IDX_STAT:
        rd_mux = {5'h00, area_out_valid_q, rx_out_valid, tx_in_ready};
      default: rd_mux = 8'h00;
    endcase
    if (!rd_ok)
      rd_mux = 8'h00;
  end

  // Write address and data are taken independently, one write at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      aw_have_q <= 1'b0;
      aw_bad_q <= 1'b0;
      aw_idx_q <= 8'h00;
      wready_q <= 1'b1;
      w_have_q <= 1'b0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end
    else if (ce)
    begin
      if (awvalid && awready_q)
      begin
        awready_q <= 1'b0;
        aw_have_q <= 1'b1;
        aw_idx_q <= awaddr[9:hpc_pkg::ADDR_LSB];
        aw_bad_q <= (awaddr[11:10] != 2'h0);
      end
      if (wvalid && wready_q)
      begin
        wready_q <= 1'b0;
        w_have_q <= 1'b1;
        wdata_q <= wdata[7:0];
        wstrb0_q <= wstrb[0];
      end
      if (bvalid_q && bready)
      begin
        awready_q <= 1'b1;
        aw_have_q <= 1'b0;
        wready_q <= 1'b1;
        w_have_q <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wst_q <= hpc_pkg::BUS_WAIT;
      bvalid_q <= 1'b0;
      bresp_q <= hpc_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      case (wst_q)
        hpc_pkg::BUS_WAIT:
          if (do_write)
          begin
            wst_q <= hpc_pkg::BUS_RESP;
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? hpc_pkg::RESP_OKAY : hpc_pkg::RESP_SLVERR;
          end
        hpc_pkg::BUS_RESP:
          if (bready)
          begin
            wst_q <= hpc_pkg::BUS_WAIT;
            bvalid_q <= 1'b0;
          end
        default: wst_q <= hpc_pkg::BUS_WAIT;
      endcase
    end
  end

  // Read channel answers one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 8'h00;
      rresp_q <= hpc_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (ar_take)
      begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_ok ? hpc_pkg::RESP_OKAY : hpc_pkg::RESP_SLVERR;
      end
      else if (rvalid_q && rready)
      begin
        arready_q <= 1'b1;
        rvalid_q <= 1'b0;
      end
    end
  end

  // Unlock key, writable at all times including sleep
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      key_q <= hpc_pkg::KEY_RST;
    else if (ce && do_write && wr_ok && wstrb0_q
      && aw_idx_q == hpc_pkg::IDX_KEY)
      key_q <= wdata_q;
  end

  // Guarded registers; a locked write still answers OKAY
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_q <= hpc_pkg::CLK_RST;
      hpc_rw_q <= hpc_pkg::HPC_RST[7:3];
    end
    else if (ce && do_write && wr_ok && wstrb0_q && cfg_open)
    begin
      if (aw_idx_q == hpc_pkg::IDX_CLK)
        clk_q <= {wdata_q[7], 5'h00, wdata_q[1:0]};
      if (aw_idx_q == hpc_pkg::IDX_HPC)
        hpc_rw_q <= wdata_q[7:3];
    end
  end

  // Straps are caught on the first enabled edge after reset release
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      strap_q <= hpc_pkg::HPC_RST[2:1];
      init_done_q <= hpc_pkg::HPC_RST[0];
      strap_taken_q <= 1'b0;
    end
    else if (ce && !strap_taken_q)
    begin
      strap_q <= {byte_swap_strap, write_strobe_strap};
      strap_taken_q <= 1'b1;
    end
  end

  // Data path control: mode and direction
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_q <= hpc_pkg::CTRL_RST;
    else if (ce && do_write && wr_ok && wstrb0_q
      && aw_idx_q == hpc_pkg::IDX_CTRL)
      ctrl_q <= wdata_q[1:0];
  end

  byte_fifo #(
    .WIDTH(hpc_pkg::BYTE_W),
    .DEPTH(hpc_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .in_valid(tx_push),
    .in_ready(tx_in_ready),
    .in_data(wdata_q),
    .out_valid(tx_out_valid),
    .out_ready(tx_out_ready),
    .out_data(tx_out_data)
  );

  byte_fifo #(
    .WIDTH(hpc_pkg::BYTE_W),
    .DEPTH(hpc_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .in_valid(area_in_valid),
    .in_ready(rx_in_ready),
    .in_data(area_in_data),
    .out_valid(rx_out_valid),
    .out_ready(rx_pop),
    .out_data(rx_out_data)
  );

  // Output stage keeps the area port straight from flops
  assign tx_out_ready = !area_out_valid_q || area_out_ready;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      area_out_valid_q <= 1'b0;
      area_out_data_q <= 8'h00;
    end
    else if (ce && tx_out_ready)
    begin
      area_out_valid_q <= tx_out_valid;
      area_out_data_q <= tx_out_data;
    end
  end

  // External clock input enable, held off in CPU-cut mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ext_clk_q <= 1'b0;
    else if (ce)
      ext_clk_q <= clk_q.origin && !cpu_cut_mode;
  end

  // Interrupt pin: polarity and drive style
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_o_q <= 1'b1;
      irq_oe_n_q <= 1'b0;
    end
    else if (ce)
    begin
      irq_o_q <= irq_event ~^ hpc.irq_polarity;
      irq_oe_n_q <= hpc.irq_drive_style && !irq_event;
    end
  end

  // DMA request asks for room or data only outside register DMA mode
  assign req_active = !ctrl_q.dma_mode
    && (ctrl_q.dir_read ? rx_out_valid : tx_in_ready);
  assign ack_active = dma_ack_pin ~^ hpc.dma_ack_polarity;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dreq_q <= 1'b1;
      dacc_q <= 1'b0;
    end
    else if (ce)
    begin
      dreq_q <= req_active ~^ hpc.dma_request_polarity;
      dacc_q <= ack_active && (!hpc.cs_qualify || !chip_select_pin_n);
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = {24'h000000, rdata_q};
  assign rresp = rresp_q;
  assign area_in_ready = rx_in_ready;
  assign area_out_valid = area_out_valid_q;
  assign area_out_data = area_out_data_q;
  assign clock_origin_select = clk_q.origin;
  assign input_frequency_code = clk_q.freq;
  assign ext_clk_enable = ext_clk_q;
  assign irq_out_pin_o = irq_o_q;
  assign irq_out_pin_oe_n = irq_oe_n_q;
  assign dma_request_pin = dreq_q;
  assign dma_access = dacc_q;

  // Checks next to the logic they guard
  a_pop_needs_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_pop |-> ctrl_q.dma_mode && ctrl_q.dir_read ##1 rvalid_q)
    else $error("read pop outside register read mode");
  a_push_needs_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_push |-> ctrl_q.dma_mode && !ctrl_q.dir_read ##1 bvalid_q)
    else $error("write push outside register write mode");
  a_locked_clk_kept: assert property (@(posedge aclk)
    disable iff (!aresetn || !ce)
    do_write && !cfg_open |=> $stable(clk_q) && $stable(hpc_rw_q))
    else $error("locked configuration changed");
  a_open_clk_write: assert property (@(posedge aclk)
    disable iff (!aresetn || !ce)
    do_write && wr_ok && wstrb0_q && cfg_open && aw_idx_q == hpc_pkg::IDX_CLK
    |=> clk_q.freq == $past(wdata_q[1:0]) && clk_q.rsvd == 5'h00)
    else $error("unlocked clock write not stored");
  a_sleep_key_write: assert property (@(posedge aclk)
    disable iff (!aresetn || !ce)
    sleep_mode && do_write && wstrb0_q && aw_idx_q == hpc_pkg::IDX_KEY
    && !aw_bad_q |=> key_q == $past(wdata_q) && bvalid_q)
    else $error("key write refused in sleep");
  a_ext_clk_src: assert property (@(posedge aclk)
    disable iff (!aresetn || !ce)
    ext_clk_q |-> $past(clk_q.origin) && !$past(cpu_cut_mode))
    else $error("external clock enabled without its source");
  a_cut_clk_off: assert property (@(posedge aclk)
    disable iff (!aresetn || !ce)
    cpu_cut_mode [*2] |-> !ext_clk_q)
    else $error("external clock on in CPU-cut mode");
  a_irq_level: assert property (@(posedge aclk)
    disable iff (!aresetn || !ce)
    irq_event && hpc.irq_polarity |=> irq_o_q)
    else $error("interrupt polarity wrong");
  a_irq_release: assert property (@(posedge aclk)
    disable iff (!aresetn || !ce)
    !irq_event && hpc.irq_drive_style
    |=> irq_oe_n_q && irq_o_q == !$past(hpc.irq_polarity))
    else $error("interrupt pin driven while idle in release mode");
  a_dreq_polarity: assert property (@(posedge aclk)
    disable iff (!aresetn || !ce)
    !req_active |=> dreq_q == !$past(hpc.dma_request_polarity))
    else $error("DMA request idle level wrong");
  a_cs_qualify: assert property (@(posedge aclk)
    disable iff (!aresetn || !ce)
    hpc.cs_qualify && chip_select_pin_n |=> !dacc_q)
    else $error("DMA access without chip select");
  a_init_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    strap_taken_q && $past(strap_taken_q)
    |-> hpc.init_done && $stable(strap_q))
    else $error("initialised flag or straps moved");
endmodule : hpc_regs

// *** hpc_pkg.sv ***
// Constants and types for the host port configuration register bank
package hpc_pkg;
  // Register indices; byte address is the index shifted by ADDR_LSB
  localparam int ADDR_LSB = 2;
  localparam logic [7:0] IDX_RD_LO = 8'h6c;
  localparam logic [7:0] IDX_RD_HI = 8'h6d;
  localparam logic [7:0] IDX_WR_LO = 8'h6e;
  localparam logic [7:0] IDX_WR_HI = 8'h6f;
  localparam logic [7:0] IDX_KEY = 8'h71;
  localparam logic [7:0] IDX_CLK = 8'h73;
  localparam logic [7:0] IDX_HPC = 8'h75;
  localparam logic [7:0] IDX_CTRL = 8'h76;
  localparam logic [7:0] IDX_STAT = 8'h77;
  // Values after reset and the unlock code
  localparam logic [7:0] UNLOCK_CODE = 8'h56;
  localparam logic [7:0] KEY_RST = 8'h56;
  localparam logic [7:0] CLK_RST = 8'h00;
  localparam logic [7:0] HPC_RST = 8'h01;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // Input frequency codes
  localparam logic [1:0] FREQ_12 = 2'h0;
  localparam logic [1:0] FREQ_24 = 2'h1;
  localparam logic [1:0] FREQ_48 = 2'h3;
  // Data path geometry
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 4;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic origin;
    logic [4:0] rsvd;
    logic [1:0] freq;
  } clk_setup_t;

  typedef struct packed {
    logic irq_polarity;
    logic irq_drive_style;
    logic dma_request_polarity;
    logic dma_ack_polarity;
    logic cs_qualify;
    logic byte_swap;
    logic write_strobe_style;
    logic init_done;
  } host_cfg_t;

  typedef struct packed {
    logic dir_read;
    logic dma_mode;
  } dma_ctrl_t;

  typedef enum logic [0:0] {
    BUS_WAIT = 1'b0,
    BUS_RESP = 1'b1
  } bus_state_t;
endpackage : hpc_pkg

// *** area_partner.sv ***
// Far-side model: byte source into the receive area, sink for transmit bytes
module area_partner (
  input wire logic aclk,
  input wire logic area_in_ready,
  output logic area_in_valid,
  output logic [7:0] area_in_data,
  input wire logic area_out_valid,
  output logic area_out_ready,
  input wire logic [7:0] area_out_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] send_q[$];
  logic [7:0] got_q[$];
  logic hold = 1'b0;
  logic [1:0] slow_q = 2'h0;
  initial
  begin
    area_in_valid = 1'b0;
    area_in_data = 8'h00;
    area_out_ready = 1'b0;
  end
  // Source holds a byte until taken; the released line shows its inverse
  always @(posedge aclk)
  begin
    if (area_in_valid && area_in_ready)
    begin
      area_in_valid <= 1'b0;
      area_in_data <= ~area_in_data;
    end
    else if (!area_in_valid && send_q.size() > 0)
    begin
      area_in_valid <= 1'b1;
      area_in_data <= send_q.pop_front();
    end
  end
  // Sink stalls one cycle in four, and fully while hold is set
  always @(posedge aclk)
  begin
    slow_q <= slow_q + 2'h1;
    area_out_ready <= !hold && slow_q != 2'h0;
    if (area_out_valid && area_out_ready)
      got_q.push_back(area_out_data);
  end
endmodule : area_partner

// *** tb_top.sv ***
// Self-checking bench for the host port configuration register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] ok = hpc_pkg::RESP_OKAY;
  localparam logic [1:0] err = hpc_pkg::RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn, ce, awvalid, wvalid, bready, arvalid, rready, sleep_mode;
  logic cpu_cut_mode, byte_swap_strap, write_strobe_strap, irq_event;
  logic dma_ack_pin, chip_select_pin_n, awready, wready, bvalid, arready;
  logic rvalid, area_in_valid, area_in_ready, area_out_valid, area_out_ready;
  logic clock_origin_select, ext_clk_enable, irq_out_pin_o, irq_out_pin_oe_n;
  logic dma_request_pin, dma_access;
  logic [1:0] bresp, rresp, input_frequency_code;
  logic [3:0] wstrb;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [7:0] area_in_data, area_out_data, h, b;
  logic [7:0] exp_q[$];
  int mismatches = 0;
  int n_compared = 0;
  int seed = 32'hba8af1e4;

  hpc_regs hpc_regs_i (.aclk, .aresetn, .ce, .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .sleep_mode,
    .cpu_cut_mode, .byte_swap_strap, .write_strobe_strap, .irq_event,
    .dma_ack_pin, .chip_select_pin_n, .area_in_valid, .area_in_ready,
    .area_in_data, .area_out_valid, .area_out_ready, .area_out_data,
    .clock_origin_select, .input_frequency_code, .ext_clk_enable,
    .irq_out_pin_o, .irq_out_pin_oe_n, .dma_request_pin, .dma_access);

  area_partner area_partner_i (.aclk, .area_in_ready, .area_in_valid,
    .area_in_data, .area_out_valid, .area_out_ready, .area_out_data);

  // 20 MHz clock
  always #25 aclk = ~aclk;

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ba

  // Host configuration readback: strap bits and init flag replace bits 2:0
  function automatic logic [7:0] hpc_of(input logic [7:0] w);
    return {w[7:3], byte_swap_strap, write_strobe_strap, 1'b1};
  endfunction : hpc_of

  task automatic chk(input string what, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // Address and data offered together, each released once taken
  task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= ba(idx);
    wdata <= {24'h0, d};
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    chk("bresp", ok, bresp);
  endtask : axi_wr

  task automatic rchk(input logic [11:0] a, input logic [7:0] e,
    input logic [1:0] er);
    arvalid <= 1'b1;
    araddr <= a;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    chk("rdata", {24'h0, e}, rdata);
    chk("rresp", er, rresp);
  endtask : rchk

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // Watchdog: the whole sequence needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    conclude();
  end

  initial
  begin
    {aresetn, awvalid, wvalid, arvalid, sleep_mode, cpu_cut_mode} = '0;
    {irq_event, dma_ack_pin, chip_select_pin_n} = '0;
    {ce, bready, rready} = 3'h7;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'h1;
    byte_swap_strap = 1'($random(seed));
    write_strobe_strap = 1'($random(seed));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(ba(hpc_pkg::IDX_KEY), 8'h56, ok);
    rchk(ba(hpc_pkg::IDX_CLK), 8'h00, ok);
    rchk(ba(hpc_pkg::IDX_HPC), hpc_of(8'h01), ok);
    $display("Test reset values done");
    // Every frequency code; 48 MHz only with the external pin
    for (int k = 0; k < 3; k++)
    begin
      h = {k == 2 || 1'($random(seed)), 5'h0, k == 2 ? 2'h3 : 2'(k)};
      axi_wr(hpc_pkg::IDX_CLK, h);
      rchk(ba(hpc_pkg::IDX_CLK), h, ok);
      chk("origin", h[7], clock_origin_select);
      chk("freq", h[1:0], input_frequency_code);
    end
    cpu_cut_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("ext_clk", 0, ext_clk_enable);
    cpu_cut_mode <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("ext_clk", 1, ext_clk_enable);
    $display("Test clock setup done");
    // Lock with a value one off the key, then try to overwrite
    h = 8'($random(seed));
    axi_wr(hpc_pkg::IDX_HPC, h);
    axi_wr(hpc_pkg::IDX_KEY, 8'h57);
    axi_wr(hpc_pkg::IDX_CLK, 8'h01);
    axi_wr(hpc_pkg::IDX_HPC, ~h);
    rchk(ba(hpc_pkg::IDX_KEY), 8'h57, ok);
    rchk(ba(hpc_pkg::IDX_CLK), 8'h83, ok);
    rchk(ba(hpc_pkg::IDX_HPC), hpc_of(h), ok);
    axi_wr(hpc_pkg::IDX_KEY, 8'h56);
    $display("Test lock done");
    for (int i = 0; i < 8; i++)
    begin
      h = 8'($random(seed));
      axi_wr(hpc_pkg::IDX_HPC, h);
      irq_event <= 1'($random(seed));
      dma_ack_pin <= 1'($random(seed));
      chip_select_pin_n <= 1'($random(seed));
      repeat (2) @(posedge aclk);
      chk("irq_o", {irq_event ~^ h[7]}, irq_out_pin_o);
      chk("irq_oe_n", {h[6] & ~irq_event}, irq_out_pin_oe_n);
      chk("dreq", h[5], dma_request_pin);
      chk("access", {dma_ack_pin == h[4] && !(h[3] && chip_select_pin_n)},
        dma_access);
    end
    $display("Test pins done");
    sleep_mode <= 1'b1;
    axi_wr(hpc_pkg::IDX_CLK, 8'h01);
    rchk(ba(hpc_pkg::IDX_CLK), 8'h01, ok);
    // Key stays writable in sleep: lock, read back, then reopen
    axi_wr(hpc_pkg::IDX_KEY, 8'h00);
    rchk(ba(hpc_pkg::IDX_KEY), 8'h00, ok);
    axi_wr(hpc_pkg::IDX_KEY, 8'h56);
    rchk(ba(hpc_pkg::IDX_KEY), 8'h56, ok);
    rchk(ba(hpc_pkg::IDX_RD_LO), 8'h00, err);
    sleep_mode <= 1'b0;
    rchk(12'h000, 8'h00, err);
    $display("Test sleep and unmapped done");
    // Transmit: fill FIFO and output register while the sink holds off
    axi_wr(hpc_pkg::IDX_CTRL, 8'h01);
    area_partner_i.hold <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      if (i == 5)
      begin
        rchk(ba(hpc_pkg::IDX_STAT), 8'h04, ok);
        area_partner_i.hold <= 1'b0;
      end
      b = 8'($random(seed));
      exp_q.push_back(b);
      axi_wr(i[0] ? hpc_pkg::IDX_WR_HI : hpc_pkg::IDX_WR_LO, b);
    end
    for (int n = 0; n < 300 && area_partner_i.got_q.size() < 6; n++)
      @(posedge aclk);
    for (int i = 0; i < 6; i++)
      chk("tx byte", exp_q[i], area_partner_i.got_q[i]);
    $display("Test transmit done");
    // Receive: five bytes against a four-deep FIFO
    axi_wr(hpc_pkg::IDX_CTRL, 8'h03);
    exp_q = {};
    for (int i = 0; i < 5; i++)
    begin
      b = 8'($random(seed));
      exp_q.push_back(b);
      area_partner_i.send_q.push_back(b);
    end
    for (int n = 0; n < 100 && area_in_ready; n++)
      @(posedge aclk);
    chk("rx ready", 0, area_in_ready);
    for (int i = 0; i < 5; i++)
      rchk(ba(i[0] ? hpc_pkg::IDX_RD_HI : hpc_pkg::IDX_RD_LO), exp_q[i],
        ok);
    rchk(ba(hpc_pkg::IDX_RD_LO), 8'h00, ok);
    $display("Test receive done");
    conclude();
  end
endmodule : tb_top
